// ### core/sspm_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the sleep power manager
// Assumes: byte-wide registers on a plain address/strobe port
// Notes:   included by bare name
`ifndef SSPM_DEFINES_SVH
`define SSPM_DEFINES_SVH

`define SSPM_ADDR_SLEEP_CFG      8'h00
`define SSPM_ADDR_AWAKE_CFG      8'h01
`define SSPM_ADDR_PD_CMD         8'h02
`define SSPM_ADDR_IRQ_EN_LO      8'h03
`define SSPM_ADDR_IRQ_EN_HI      8'h04
`define SSPM_ADDR_ST_CMP_LO      8'h05
`define SSPM_ADDR_ST_CMP_HI      8'h06
`define SSPM_ADDR_AT_CMP_LO      8'h07
`define SSPM_ADDR_AT_CMP_HI      8'h08
`define SSPM_ADDR_ST_CNT_LO      8'h09
`define SSPM_ADDR_ST_CNT_HI      8'h0a
`define SSPM_ADDR_STATUS         8'h0b
`define SSPM_ADDR_CONV_CNT       8'h0c

`define SSPM_PD_KEY              8'ha9

// sleep config fields
`define SSPM_SC_TARGET_LSB       0
`define SSPM_SC_MEAS_LSB         2
`define SSPM_SC_BIAS_LOW_BIT     5
`define SSPM_SC_BIAS_ULTRA_BIT   6
`define SSPM_SC_REFBUF_BIT       7
`define SSPM_SLEEP_CFG_RST       8'h20

// awake config fields
`define SSPM_AC_ADC_I_BIT        0
`define SSPM_AC_ADC_V_BIT        1
`define SSPM_AC_BIAS_LOW_BIT     2
`define SSPM_AC_BIAS_ULTRA_BIT   3
`define SSPM_AC_REFBUF_BIT       4
`define SSPM_AWAKE_CFG_RST       8'h00

// wake source bits of the interrupt enable mask
`define SSPM_IRQ_WDOG_BIT        0
`define SSPM_IRQ_STIMER_BIT      1
`define SSPM_IRQ_LINWAKE_BIT     4
`define SSPM_IRQ_CUR_ADC_MASK    16'h0f00

// status bits
`define SSPM_ST_VALID_BIT        1
`define SSPM_ST_REACHED_BIT      0

`define SSPM_CLK_HZ              125000000
`define SSPM_LP_CLK_HZ           125000
`define SSPM_LP_DIV              (`SSPM_CLK_HZ / `SSPM_LP_CLK_HZ)
`define SSPM_SETTLE_US           100
`define SSPM_SETTLE_CYC          ((`SSPM_SETTLE_US * (`SSPM_CLK_HZ / 1000000)))

`endif

// ### core/sspm_pkg.sv
// Purpose: types of the sleep power manager
// Assumes: constants live in sspm_defines.svh
// Notes:   none
package sspm_pkg;

    typedef enum logic [2:0]
    {
        ST_AWAKE,
        ST_ARMED,
        ST_ENTER,
        ST_SLEEP,
        ST_MEASURE,
        ST_SETTLE
    } sspm_state_e;

    typedef struct packed
    {
        logic       hp_osc_on;
        logic       line_tx_on;
        logic       host_clk_on;
        logic       io_reg_on;
        logic       core_reg_on;
        logic       lp_clk_sel;
        logic       div_clk_run;
        logic [1:0] bias_cut;
        logic       refbuf_oc_on;
        logic       adc_i_pwr;
        logic       adc_v_pwr;
    } sspm_power_s;

    typedef struct packed
    {
        logic       start;
        logic       stop;
        logic [1:0] mode;
    } sspm_adc_ctl_s;

endpackage

// ### core/sspm_top.sv
// Purpose: sleep and deep-sleep power manager with timers and sleep-time current sampling
// Assumes: one clock, low-rate sleep tick made by a divider enable; host on a register port
// Notes:   wake event inputs are level requests from the interrupt block, ungated on arrival and enable-gated per bit here
//
// What this block does
// - sleep powers down transmitter, oscillator, host clock
// - sleep uses low rate clock, divided stopped
// - deep sleep drops both regulators, indicator low
// - analog power and adc controls follow setup
// - target select 0,1 light, 2 deep
// - setup 0 idle, 1 discrete current
// - bias cut bits give 10,5,15 percent
// - sleep bias defaults low cut, awake none
// - sleep refbuf bit powers up, awake powers down
// - sleep refbuf bit resets to zero
// - entry clears sleep and trigger timers
// - sleep timer always runs, trigger only discrete
// - compare wakes if enabled, else timer halts
// - status bit shows compare reached
// - awake stops sleep timer, count stays readable
// - idle setup: adcs off, three wake sources
// - enable bits 0,1,4 gate wake sources
// - enabled event wakes, awake settings restored
// - after settle host clock on, deep releases reset
// - discrete: current adc only on trigger
// - current adc events wake, abort conversion
// - pending wake refuses or reverses entry
// - refused entry clears timer valid flag
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "sspm_defines.svh"

module sspm_top
(
    input  wire logic                  CLK_I,
    input  wire logic                  RST_I,
    input  wire logic [7:0]            ADDR_I,
    input  wire logic [7:0]            WDATA_I,
    input  wire logic                  WR_I,
    input  wire logic                  RD_I,
    output logic      [7:0]            RDATA_O,
    input  wire logic                  CHIP_SELECT_N_I,
    input  wire logic [15:0]           IRQ_EVENT_I,
    input  wire logic                  ADC_DONE_I,
    output sspm_pkg::sspm_power_s      POWER_O,
    output sspm_pkg::sspm_adc_ctl_s    ADC_CTL_O,
    output logic                       SLEEP_INDICATOR_N_O,
    output logic                       HOST_RESET_N_O,
    output logic                       ADC_OWNED_O
);

    sspm_pkg::sspm_state_e state_reg;
    logic [7:0]  sleep_power_config_reg;
    logic [7:0]  awake_power_config_reg;
    logic [15:0] interrupt_enable_mask_reg;
    logic [15:0] sleep_timer_compare_reg;
    logic [15:0] adc_trigger_compare_reg;
    logic [15:0] sleep_timer_count_reg;
    logic [15:0] adc_trigger_count_reg;
    logic [7:0]  conv_per_trigger_reg;
    logic [7:0]  conv_left_reg;
    logic        timer_valid_reg;
    logic        timer_reached_reg;
    logic        cmd_armed_reg;
    logic        deep_reg;
    logic [9:0]  div_reg;
    logic        tick_reg;
    logic [15:0] settle_reg;
    logic [2:0]  cs_sync_reg;
    logic [15:0] irq_s1_reg;
    logic [15:0] irq_s2_reg;
    logic [15:0] irq_s3_reg;
    logic [1:0]  sleep_target_select;
    logic [2:0]  sleep_measure_setup;
    logic        discrete;
    logic [15:0] wake_mask;
    logic        wake;
    logic        cs_high;

    assign sleep_target_select = sleep_power_config_reg[`SSPM_SC_TARGET_LSB +: 2];
    assign sleep_measure_setup = sleep_power_config_reg[`SSPM_SC_MEAS_LSB +: 3];
    assign discrete            = (sleep_measure_setup == 3'h1);
    assign cs_high             = cs_sync_reg[1] & cs_sync_reg[2];

    // wake sources allowed by the selected setup, gated by the enable mask
    assign wake_mask = (16'h0001 << `SSPM_IRQ_WDOG_BIT) | (16'h0001 << `SSPM_IRQ_STIMER_BIT)
                     | (16'h0001 << `SSPM_IRQ_LINWAKE_BIT)
                     | (discrete ? `SSPM_IRQ_CUR_ADC_MASK : 16'h0000);

    // stable-event sampling: the second and third stages must agree
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            irq_s1_reg  <= 16'h0000;
            irq_s2_reg  <= 16'h0000;
            irq_s3_reg  <= 16'h0000;
            cs_sync_reg <= 3'h7;
        end
        else
        begin
            irq_s1_reg  <= IRQ_EVENT_I;
            irq_s2_reg  <= irq_s1_reg;
            irq_s3_reg  <= irq_s2_reg;
            cs_sync_reg <= {cs_sync_reg[1:0], CHIP_SELECT_N_I};
        end
    end

    assign wake = |(irq_s2_reg & irq_s3_reg & interrupt_enable_mask_reg & wake_mask)
                | (timer_reached_reg & interrupt_enable_mask_reg[`SSPM_IRQ_STIMER_BIT] & POWER_O.lp_clk_sel);

    // register writes
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            sleep_power_config_reg    <= `SSPM_SLEEP_CFG_RST;
            awake_power_config_reg    <= `SSPM_AWAKE_CFG_RST;
            interrupt_enable_mask_reg <= 16'h0000;
            sleep_timer_compare_reg   <= 16'hffff;
            adc_trigger_compare_reg   <= 16'hffff;
            conv_per_trigger_reg      <= 8'h01;
        end
        else if (WR_I)
        begin
            case (ADDR_I)
                `SSPM_ADDR_SLEEP_CFG:  sleep_power_config_reg          <= WDATA_I;
                `SSPM_ADDR_AWAKE_CFG:  awake_power_config_reg          <= WDATA_I;
                `SSPM_ADDR_IRQ_EN_LO:  interrupt_enable_mask_reg[7:0]  <= WDATA_I;
                `SSPM_ADDR_IRQ_EN_HI:  interrupt_enable_mask_reg[15:8] <= WDATA_I;
                `SSPM_ADDR_ST_CMP_LO:  sleep_timer_compare_reg[7:0]    <= WDATA_I;
                `SSPM_ADDR_ST_CMP_HI:  sleep_timer_compare_reg[15:8]   <= WDATA_I;
                `SSPM_ADDR_AT_CMP_LO:  adc_trigger_compare_reg[7:0]    <= WDATA_I;
                `SSPM_ADDR_AT_CMP_HI:  adc_trigger_compare_reg[15:8]   <= WDATA_I;
                `SSPM_ADDR_CONV_CNT:   conv_per_trigger_reg            <= WDATA_I;
                default:               ;
            endcase
        end
    end

    // register reads, data one cycle after the strobe
    always_ff @(posedge CLK_I)
    begin
        if (RST_I || !RD_I)
        begin
            RDATA_O <= 8'h00;
        end
        else
        begin
            case (ADDR_I)
                `SSPM_ADDR_SLEEP_CFG:  RDATA_O <= sleep_power_config_reg;
                `SSPM_ADDR_AWAKE_CFG:  RDATA_O <= awake_power_config_reg;
                `SSPM_ADDR_IRQ_EN_LO:  RDATA_O <= interrupt_enable_mask_reg[7:0];
                `SSPM_ADDR_IRQ_EN_HI:  RDATA_O <= interrupt_enable_mask_reg[15:8];
                `SSPM_ADDR_ST_CMP_LO:  RDATA_O <= sleep_timer_compare_reg[7:0];
                `SSPM_ADDR_ST_CMP_HI:  RDATA_O <= sleep_timer_compare_reg[15:8];
                `SSPM_ADDR_AT_CMP_LO:  RDATA_O <= adc_trigger_compare_reg[7:0];
                `SSPM_ADDR_AT_CMP_HI:  RDATA_O <= adc_trigger_compare_reg[15:8];
                `SSPM_ADDR_ST_CNT_LO:  RDATA_O <= sleep_timer_count_reg[7:0];
                `SSPM_ADDR_ST_CNT_HI:  RDATA_O <= sleep_timer_count_reg[15:8];
                `SSPM_ADDR_STATUS:     RDATA_O <= {6'h00, timer_valid_reg, timer_reached_reg};
                `SSPM_ADDR_CONV_CNT:   RDATA_O <= conv_per_trigger_reg;
                default:               RDATA_O <= 8'h00;
            endcase
        end
    end

    // low-rate sleep tick
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            div_reg  <= 10'h000;
            tick_reg <= 1'b0;
        end
        else if (div_reg == 10'(`SSPM_LP_DIV - 1))
        begin
            div_reg  <= 10'h000;
            tick_reg <= 1'b1;
        end
        else
        begin
            div_reg  <= div_reg + 10'h001;
            tick_reg <= 1'b0;
        end
    end

    // power manager sequence
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            state_reg     <= sspm_pkg::ST_AWAKE;
            cmd_armed_reg <= 1'b0;
            deep_reg      <= 1'b0;
            settle_reg    <= 16'h0000;
            conv_left_reg <= 8'h00;
        end
        else
        begin
            case (state_reg)
                sspm_pkg::ST_AWAKE:
                begin
                    if (WR_I && ADDR_I == `SSPM_ADDR_PD_CMD && WDATA_I == `SSPM_PD_KEY)
                    begin
                        state_reg <= sspm_pkg::ST_ARMED;
                    end
                end
                sspm_pkg::ST_ARMED:
                begin
                    if (wake)
                    begin
                        state_reg <= sspm_pkg::ST_AWAKE;
                    end
                    else if (cs_high)
                    begin
                        state_reg <= sspm_pkg::ST_ENTER;
                        deep_reg  <= (sleep_target_select == 2'h2);
                    end
                end
                sspm_pkg::ST_ENTER:
                begin
                    state_reg <= wake ? sspm_pkg::ST_SETTLE : sspm_pkg::ST_SLEEP;
                    settle_reg <= 16'(`SSPM_SETTLE_CYC);
                end
                sspm_pkg::ST_SLEEP:
                begin
                    settle_reg <= 16'(`SSPM_SETTLE_CYC);
                    if (wake)
                    begin
                        state_reg <= sspm_pkg::ST_SETTLE;
                    end
                    else if (discrete && tick_reg && adc_trigger_count_reg >= adc_trigger_compare_reg)
                    begin
                        state_reg     <= sspm_pkg::ST_MEASURE;
                        conv_left_reg <= conv_per_trigger_reg;
                    end
                end
                sspm_pkg::ST_MEASURE:
                begin
                    if (wake)
                    begin
                        state_reg <= sspm_pkg::ST_SETTLE;
                    end
                    else if (ADC_DONE_I)
                    begin
                        conv_left_reg <= conv_left_reg - 8'h01;
                        if (conv_left_reg <= 8'h01)
                        begin
                            state_reg <= sspm_pkg::ST_SLEEP;
                        end
                    end
                end
                sspm_pkg::ST_SETTLE:
                begin
                    if (settle_reg == 16'h0000)
                    begin
                        state_reg <= sspm_pkg::ST_AWAKE;
                        deep_reg  <= 1'b0;
                    end
                    else
                    begin
                        settle_reg <= settle_reg - 16'h0001;
                    end
                end
                default:               state_reg <= sspm_pkg::ST_AWAKE;
            endcase
        end
    end

    // sleep timer and trigger timer
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            sleep_timer_count_reg <= 16'h0000;
            adc_trigger_count_reg <= 16'h0000;
            timer_reached_reg     <= 1'b0;
            timer_valid_reg       <= 1'b0;
        end
        else if (state_reg == sspm_pkg::ST_ARMED && wake)
        begin
            timer_valid_reg <= 1'b0;
        end
        else if (state_reg == sspm_pkg::ST_ENTER)
        begin
            sleep_timer_count_reg <= 16'h0000;
            adc_trigger_count_reg <= 16'h0000;
            timer_reached_reg     <= 1'b0;
            timer_valid_reg       <= 1'b1;
        end
        else if ((state_reg == sspm_pkg::ST_SLEEP || state_reg == sspm_pkg::ST_MEASURE) && tick_reg)
        begin
            if (sleep_timer_count_reg >= sleep_timer_compare_reg)
            begin
                timer_reached_reg <= 1'b1;
            end
            else
            begin
                sleep_timer_count_reg <= sleep_timer_count_reg + 16'h0001;
            end
            if (discrete)
            begin
                adc_trigger_count_reg <= (adc_trigger_count_reg >= adc_trigger_compare_reg) ?
                                         16'h0000 : adc_trigger_count_reg + 16'h0001;
            end
        end
    end

    // power and clock outputs
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            POWER_O             <= '0;
            ADC_CTL_O           <= '0;
            SLEEP_INDICATOR_N_O <= 1'b1;
            HOST_RESET_N_O      <= 1'b1;
            ADC_OWNED_O         <= 1'b0;
        end
        else if (state_reg == sspm_pkg::ST_SLEEP || state_reg == sspm_pkg::ST_MEASURE)
        begin
            POWER_O.hp_osc_on    <= 1'b0;
            POWER_O.line_tx_on   <= 1'b0;
            POWER_O.host_clk_on  <= 1'b0;
            POWER_O.lp_clk_sel   <= 1'b1;
            POWER_O.div_clk_run  <= 1'b0;
            POWER_O.io_reg_on    <= ~deep_reg;
            POWER_O.core_reg_on  <= ~deep_reg;
            SLEEP_INDICATOR_N_O  <= ~deep_reg;
            HOST_RESET_N_O       <= ~deep_reg;
            POWER_O.bias_cut     <= {sleep_power_config_reg[`SSPM_SC_BIAS_ULTRA_BIT],
                                     sleep_power_config_reg[`SSPM_SC_BIAS_LOW_BIT]};
            POWER_O.refbuf_oc_on <= sleep_power_config_reg[`SSPM_SC_REFBUF_BIT];
            POWER_O.adc_i_pwr    <= (state_reg == sspm_pkg::ST_MEASURE);
            POWER_O.adc_v_pwr    <= 1'b0;
            ADC_CTL_O.start      <= (state_reg == sspm_pkg::ST_MEASURE);
            ADC_CTL_O.stop       <= (state_reg == sspm_pkg::ST_MEASURE) && wake;
            ADC_CTL_O.mode       <= 2'h1;
            ADC_OWNED_O          <= 1'b1;
        end
        else
        begin
            POWER_O.hp_osc_on    <= 1'b1;
            POWER_O.line_tx_on   <= 1'b1;
            POWER_O.host_clk_on  <= (state_reg != sspm_pkg::ST_SETTLE);
            POWER_O.lp_clk_sel   <= 1'b0;
            POWER_O.div_clk_run  <= 1'b1;
            POWER_O.io_reg_on    <= 1'b1;
            POWER_O.core_reg_on  <= 1'b1;
            SLEEP_INDICATOR_N_O  <= 1'b1;
            HOST_RESET_N_O       <= ~(deep_reg && state_reg == sspm_pkg::ST_SETTLE);
            POWER_O.bias_cut     <= {awake_power_config_reg[`SSPM_AC_BIAS_ULTRA_BIT],
                                     awake_power_config_reg[`SSPM_AC_BIAS_LOW_BIT]};
            POWER_O.refbuf_oc_on <= ~awake_power_config_reg[`SSPM_AC_REFBUF_BIT];
            POWER_O.adc_i_pwr    <= awake_power_config_reg[`SSPM_AC_ADC_I_BIT];
            POWER_O.adc_v_pwr    <= awake_power_config_reg[`SSPM_AC_ADC_V_BIT];
            ADC_CTL_O.start      <= 1'b0;
            ADC_CTL_O.stop       <= (state_reg == sspm_pkg::ST_ENTER);
            ADC_CTL_O.mode       <= 2'h0;
            ADC_OWNED_O          <= (state_reg == sspm_pkg::ST_ENTER);
        end
    end

endmodule

// ### tb/sspm_host.sv
// Purpose: host controller driving the register port and select pin
// Assumes: signals change by nonblocking assignment after a rising edge
// Notes:   tasks are called from the testbench
`timescale 1ns/1ps
module sspm_host
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic            cs_n_o
);
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        cs_n_o = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask
    // wake sources first, then setup, then the key
    task automatic go_sleep(input logic [15:0] m, input logic [7:0] cfg);
        wr(8'h03, m[7:0]);
        wr(8'h04, m[15:8]);
        wr(8'h00, cfg);
        wr(8'h02, 8'ha9);
    endtask
    task automatic release_cs;
        @(posedge clk_i);
        cs_n_o <= 1'b1;
    endtask
endmodule

// ### tb/sspm_properties.sv
// Purpose: port-level checks of the sleep power manager
// Assumes: sees only top module ports, bound from the testbench
// Notes:   one clock domain
`timescale 1ns/1ps
module sspm_properties
(
    input  wire logic                    CLK_I,
    input  wire logic                    RST_I,
    input  wire logic                    RD_I,
    input  wire logic [7:0]              RDATA_O,
    input  wire logic                    CHIP_SELECT_N_I,
    input  wire sspm_pkg::sspm_power_s   POWER_O,
    input  wire sspm_pkg::sspm_adc_ctl_s ADC_CTL_O,
    input  wire logic                    SLEEP_INDICATOR_N_O,
    input  wire logic                    HOST_RESET_N_O,
    input  wire logic                    ADC_OWNED_O
);
    logic slept_reg;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // remembers that a sleep was entered, so reset power-up is not a wake
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            slept_reg <= 1'b0;
        else if (POWER_O.lp_clk_sel)
            slept_reg <= 1'b1;
    end
    rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data outside read slot");
    sleep_clock_a: assert property (POWER_O.lp_clk_sel |-> !POWER_O.host_clk_on && !POWER_O.div_clk_run)
        else $error("clocks running while on low rate clock");
    deep_regs_a: assert property (!SLEEP_INDICATOR_N_O |-> !POWER_O.io_reg_on && !POWER_O.core_reg_on)
        else $error("regulator on in deep sleep");
    deep_hold_a: assert property (!SLEEP_INDICATOR_N_O |-> !HOST_RESET_N_O)
        else $error("host reset released in deep sleep");
    vadc_off_a: assert property (POWER_O.lp_clk_sel |-> !POWER_O.adc_v_pwr)
        else $error("voltage adc powered in sleep");
    start_mode_a: assert property (ADC_CTL_O.start |-> ADC_CTL_O.mode == 2'h1 && ADC_OWNED_O)
        else $error("adc start outside sleep control");
    entry_sel_a: assert property ($rose(POWER_O.lp_clk_sel) |-> $past(CHIP_SELECT_N_I, 3))
        else $error("sleep entered with select low");
    entry_owned_a: assert property ($rose(POWER_O.lp_clk_sel) |-> ADC_OWNED_O)
        else $error("adc not owned at sleep entry");
    settle_hold_a: assert property ($rose(POWER_O.hp_osc_on) && slept_reg |-> !POWER_O.host_clk_on [*8])
        else $error("host clock before settle");
    cover property ($rose(POWER_O.lp_clk_sel));
    cover property (!SLEEP_INDICATOR_N_O);
    cover property ($rose(ADC_CTL_O.start));
endmodule

// ### tb/testbench.sv
// Purpose: self-checking bench of the sleep power manager
// Assumes: expected outputs come from the config bytes held here
// Notes:   settle is 12500 cycles, timer tick 1000 cycles
`timescale 1ns/1ps
module testbench;
    logic clk, rst, adc_done, wr, rd, chip_select_n, sln, hrn, own;
    logic [15:0] irq, m;
    logic [7:0] addr, wdata, rdata, d;
    sspm_pkg::sspm_power_s pw;
    sspm_pkg::sspm_adc_ctl_s ac;
    int mismatches, checked, seed, scfg, acfg;
    sspm_host i_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .cs_n_o(chip_select_n));
    sspm_top i_dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .CHIP_SELECT_N_I(chip_select_n), .IRQ_EVENT_I(irq), .ADC_DONE_I(adc_done), .POWER_O(pw),
        .ADC_CTL_O(ac), .SLEEP_INDICATOR_N_O(sln), .HOST_RESET_N_O(hrn), .ADC_OWNED_O(own));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // power outputs expected from the stored config bytes
    function automatic logic [15:0] xpw(input int sl, input int deep);
        if (sl == 0)
            return {4'h0, 7'h7d, acfg[3], acfg[2], ~acfg[4], acfg[0], acfg[1]};
        return {4'h0, 3'h0, deep ? 2'b00 : 2'b11, 2'b10, scfg[6], scfg[5], scfg[7], 2'b00};
    endfunction
    task automatic wait_pw(input logic [15:0] msk, input logic [15:0] v, input int n);
        int i;
        @(negedge clk);
        for (i = 0; i < n && ({4'h0, pw} & msk) !== v; i++)
            @(negedge clk);
        chk(16'(i < n), 16'h1);
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #800000;
        mismatches++;
        results();
    end
    initial
    begin
        seed = 47434;
        rst = 1'b1;
        irq = 16'h0000;
        adc_done = 1'b0;
        scfg = 8'h20;
        acfg = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wait_pw(16'h0240, 16'h0200, 20);
        chk({4'h0, pw}, xpw(0, 0));
        i_host.rd(8'h00, d);
        chk(d, 8'h20);
        i_host.rd(8'h01, d);
        chk(d, 8'h00);
        i_host.rd(8'h3f, d);
        chk(d, 8'h00);
        acfg = $random(seed) & 31;
        i_host.wr(8'h01, 8'(acfg));
        i_host.wr(8'h02, 8'h55);
        i_host.release_cs;
        repeat (50) @(negedge clk);
        chk({4'h0, pw}, xpw(0, 0));
        $display("test reset and bad key done");
        for (int t = 0; t < 2; t++)
        begin
            scfg = t | ($random(seed) & 8'he0);
            m = t ? 16'h0010 : 16'h0001;
            i_host.go_sleep(m, 8'(scfg));
            repeat (20) @(negedge clk);
            chk(pw.lp_clk_sel, 0);
            i_host.release_cs;
            wait_pw(16'h0240, 16'h0040, 100);
            chk({4'h0, pw}, xpw(1, 0));
            chk(sln, 1);
            @(posedge clk) irq <= 16'h0002;
            repeat (50) @(negedge clk);
            chk(pw.lp_clk_sel, 1);
            @(posedge clk) irq <= m;
            repeat (1000) @(negedge clk);
            chk(pw.host_clk_on, 0);
            wait_pw(16'h0240, 16'h0200, 14000);
            chk({4'h0, pw}, xpw(0, 0));
            @(posedge clk) irq <= 16'h0000;
            $display("test light sleep %0d done", t);
        end
        i_host.wr(8'h05, 8'h03);
        i_host.wr(8'h06, 8'h00);
        scfg = 2 | ($random(seed) & 8'he0);
        i_host.go_sleep(16'h0002, 8'(scfg));
        i_host.release_cs;
        wait_pw(16'h0240, 16'h0040, 100);
        chk({4'h0, pw}, xpw(1, 1));
        chk({sln, hrn}, 0);
        wait_pw(16'h0240, 16'h0200, 20000);
        chk({sln, hrn}, 3);
        i_host.rd(8'h0b, d);
        chk(d[1:0], 2'b11);
        i_host.rd(8'h09, d);
        chk(d, 8'h03);
        repeat (2000) @(negedge clk);
        i_host.rd(8'h09, d);
        chk(d, 8'h03);
        $display("test deep sleep timer done");
        i_host.wr(8'h07, 8'h02);
        i_host.wr(8'h08, 8'h00);
        i_host.wr(8'h0c, 8'h02);
        scfg = 4 | ($random(seed) & 8'he0);
        i_host.go_sleep(16'h0100, 8'(scfg));
        i_host.release_cs;
        wait_pw(16'h0240, 16'h0040, 100);
        chk({4'h0, pw}, xpw(1, 0));
        chk({own, ac.start, ac.mode}, 4'h9);
        wait_pw(16'h0002, 16'h0002, 3100);
        chk({pw.adc_v_pwr, ac.mode}, 3'h1);
        repeat (2)
        begin
            @(posedge clk) adc_done <= 1'b1;
            @(posedge clk) adc_done <= 1'b0;
        end
        repeat (5) @(negedge clk);
        chk(pw.adc_i_pwr, 0);
        wait_pw(16'h0002, 16'h0002, 3100);
        @(posedge clk) irq <= 16'h0100;
        repeat (5) @(negedge clk);
        chk({own, ac.stop}, 2'b11);
        wait_pw(16'h0240, 16'h0200, 14000);
        chk({4'h0, pw}, xpw(0, 0));
        chk({own, ac}, 5'h00);
        @(posedge clk) irq <= 16'h0000;
        i_host.rd(8'h09, d);
        chk(d, 8'h03);
        $display("test discrete current done");
        @(posedge clk) irq <= 16'h0001;
        i_host.go_sleep(16'h0001, 8'h20);
        i_host.release_cs;
        repeat (200) @(negedge clk);
        chk({4'h0, pw}, xpw(0, 0));
        i_host.rd(8'h0b, d);
        chk(d[1], 0);
        @(posedge clk) irq <= 16'h0000;
        $display("test pending wake done");
        results();
    end
endmodule
bind sspm_top sspm_properties i_props (.CLK_I(CLK_I), .RST_I(RST_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .CHIP_SELECT_N_I(CHIP_SELECT_N_I), .POWER_O(POWER_O), .ADC_CTL_O(ADC_CTL_O),
    .SLEEP_INDICATOR_N_O(SLEEP_INDICATOR_N_O), .HOST_RESET_N_O(HOST_RESET_N_O), .ADC_OWNED_O(ADC_OWNED_O));
